// ===== inc/chan_cfg_pkg.sv
// Constants, field layouts and types shared by the channel global configuration logic.
package chan_cfg_pkg;

  // ****************************************************************
  // Widths and register offsets
  // ****************************************************************
  localparam int ADDR_W = 11;
  localparam int DATA_W = 8;
  localparam logic [10:0] ADDR_BANK_SELECT   = 11'h000;
  localparam logic [10:0] ADDR_MEM_FIRST     = 11'h001;
  localparam logic [10:0] ADDR_MASTER_ONE    = 11'h009;
  localparam logic [10:0] ADDR_MASTER_TWO    = 11'h00a;
  localparam logic [10:0] ADDR_BLOCK_POWER   = 11'h00b;
  localparam logic [10:0] ADDR_INPUT_ENABLE  = 11'h00c;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int BANK_BIT       = 0;
  localparam int M1_RESET_BIT   = 7;
  localparam int M1_IC1_OVR_BIT = 5;
  localparam int M1_SRC_SEL_BIT = 4;
  localparam int M1_RING_PD_BIT = 3;
  localparam int M1_DBL_BIT     = 2;
  localparam int M1_XTAL_LSB    = 0;
  localparam int M2_GPIO_LSB    = 5;
  localparam int PE_SYNTH_BIT   = 4;
  localparam int PE_LOOP_BIT    = 0;
  localparam int IC_ENABLE_LSB  = 0;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [1:0] STRAP_RESET = 2'h0;

  // ****************************************************************
  // Configuration memory and timing
  // ****************************************************************
  localparam int MEM_AW    = 6;
  localparam int MEM_DEPTH = 64;
  localparam int CLK_PERIOD_NS      = 20;
  localparam int XTAL_SETTLE_NS     = 5000000;
  localparam int XTAL_SETTLE_CYCLES = (XTAL_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_W = 18;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    XTAL_OFF    = 2'b00,
    XTAL_DRIVER = 2'b01,
    XTAL_SINGLE = 2'b10,
    XTAL_UNUSED = 2'b11
  } xtal_mode_t;

  typedef enum logic [1:0] {
    SRC_RING = 2'b00,
    SRC_XTAL = 2'b01,
    SRC_IC1  = 2'b10
  } mclk_src_t;

  typedef struct packed {
    logic       ic1Override;
    logic       srcSelect;
    logic       ringPowerDown;
    logic       doublerEnable;
    xtal_mode_t crystalMode;
    logic [1:0] gpioSelect;
    logic       synthEnable;
    logic       loopEnable;
    logic [2:0] inputEnable;
  } cfg_fields_t;

  // True when an address in the current bank belongs to the configuration memory.
  function automatic logic isMemAccess(input logic bank, input logic [10:0] addr);
    isMemAccess = bank && (addr >= ADDR_MEM_FIRST);
  endfunction

endpackage

// ===== inc/mem_port_if.sv
// Access port between the register logic and the configuration memory.
`timescale 1ns/100ps
interface mem_port_if;
  import chan_cfg_pkg::*;
  logic              wrEn;
  logic              rdEn;
  logic [MEM_AW-1:0] addr;
  logic [7:0]        wrData;
  logic [7:0]        rdData;
  modport requester (output wrEn, output rdEn, output addr, output wrData, input rdData);
  modport memory (input wrEn, input rdEn, input addr, input wrData, output rdData);
endinterface

// ===== hw/cfg_memory.sv
// Small configuration memory with registered read data.
`timescale 1ns/100ps
module cfg_memory
  import chan_cfg_pkg::*;
(
  input wire logic   sys_clk,  // System clock.
  input wire logic   sys_rst,  // Synchronous reset, active high.
  mem_port_if.memory port      // Access port.
);

  typedef struct packed {
    logic [MEM_DEPTH-1:0][7:0] words;
    logic [7:0]                rdData;
  } mem_state_t;

  mem_state_t st_ff;
  mem_state_t nxt_st;

  // ****************************************************************
  // Storage
  // ****************************************************************

  // Writes store a byte; reads load the output register one cycle later.
  always_comb begin
    nxt_st = st_ff;
    if (port.wrEn) begin
      nxt_st.words[port.addr] = port.wrData;
    end
    if (port.rdEn) begin
      nxt_st.rdData = st_ff.words[port.addr];
    end
  end

  // The reset clears the contents so reads are defined from the start.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign port.rdData = st_ff.rdData;

endmodule

// ===== hw/clk_source_decode.sv
// Registered decode of configuration fields into block enables and clock selects.
`timescale 1ns/100ps
module clk_source_decode
  import chan_cfg_pkg::*;
(
  input  wire logic        sys_clk,         // System clock.
  input  wire logic        sys_rst,         // Synchronous reset, active high.
  input  wire cfg_fields_t cfg,             // Current field values.
  input  wire logic        extSwitchEnable, // External switch enable from the loop block.
  output mclk_src_t        masterSource,    // Selected master clock source.
  output logic             ringOscEnable,   // Ring oscillator running.
  output logic             doublerOn,       // Clock doubler powered.
  output logic             xtalDriverOn,    // Crystal driver across both pins.
  output logic             xtalInputOn,     // Oscillator input receiver powered.
  output logic             singleEndedOn,   // First pin used as single-ended input.
  output logic [3:0]       extSwitchSel,    // One-hot GPIO select for the external switch.
  output logic             synthBlockOn,    // Oscillator/spread block powered.
  output logic             loopOn,          // Analog loop powered.
  output logic [2:0]       inputOn,         // Input clock receivers and dividers powered.
  output logic             synthClockReady  // Synth block on with crystal source in use.
);

  typedef struct packed {
    mclk_src_t  src;
    logic       ring;
    logic       clock_doubler_enable;
    logic       drv;
    logic       inp;
    logic       se;
    logic [3:0] sw;
    logic       synth;
    logic       loop;
    logic [2:0] ins;
    logic       ready;
  } dec_state_t;

  dec_state_t st_ff;
  dec_state_t nxt_st;

  // ****************************************************************
  // Decode
  // ****************************************************************

  // The override wins over the select bit; otherwise the select picks ring or crystal.
  always_comb begin
    nxt_st       = st_ff;
    nxt_st.src   = cfg.ic1Override ? SRC_IC1 : (cfg.srcSelect ? SRC_XTAL : SRC_RING); // [RQ6] [RQ7]
    nxt_st.ring  = !cfg.ringPowerDown;                                                  // [RQ9]
    nxt_st.clock_doubler_enable   = cfg.doublerEnable;
    nxt_st.drv   = (cfg.crystalMode == XTAL_DRIVER);                                    // [RQ11]
    nxt_st.inp   = (cfg.crystalMode == XTAL_DRIVER) || (cfg.crystalMode == XTAL_SINGLE); // [RQ11]
    nxt_st.se    = (cfg.crystalMode == XTAL_SINGLE);                                    // [RQ11]
    nxt_st.sw    = extSwitchEnable ? (4'h1 << cfg.gpioSelect) : 4'h0;                   // [RQ12]
    nxt_st.synth = cfg.synthEnable;                                                     // [RQ13]
    nxt_st.loop  = cfg.loopEnable;
    nxt_st.ins   = cfg.inputEnable;                                                     // [RQ15]
    nxt_st.ready = cfg.synthEnable && (nxt_st.src == SRC_XTAL) && nxt_st.inp;           // [RQ13]
  end

  // After reset the ring oscillator is running and selected.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_ff      <= '0;
      st_ff.src  <= SRC_RING;
      st_ff.ring <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign masterSource    = st_ff.src;
  assign ringOscEnable   = st_ff.ring;
  assign doublerOn       = st_ff.clock_doubler_enable;
  assign xtalDriverOn    = st_ff.drv;
  assign xtalInputOn     = st_ff.inp;
  assign singleEndedOn   = st_ff.se;
  assign extSwitchSel    = st_ff.sw;
  assign synthBlockOn    = st_ff.synth;
  assign loopOn          = st_ff.loop;
  assign inputOn         = st_ff.ins;
  assign synthClockReady = st_ff.ready;

endmodule

// ===== hw/channel_global_clock_config.sv
// Channel global configuration registers, soft reset and master clock control.
`timescale 1ns/100ps

// Functional notes
// [RQ1] Bank bit maps memory at 0x1 upward
// [RQ2] Bank bit write-only, read value unreliable
// [RQ3] Reset bit holds all other fields default
// [RQ4] Soft reset uses pin-latched defaults, no resample
// [RQ5] Software clears clock selects before reset
// [RQ6] Override bit forces input clock one source
// [RQ7] Select bit: ring oscillator or crystal pin
// [RQ8] Software selects crystal after oscillator is stable
// [RQ9] Power-down bit stops the ring oscillator
// [RQ10] Software waits 5ms before enabling doubler
// [RQ11] Crystal pin mode two-bit decode
// [RQ12] GPIO select valid only with switch enable
// [RQ13] Synth block enable powers oscillator block
// [RQ14] Software sets analog loop enable
// [RQ15] Three input clock enables
// [RQ16] Unimplemented bits ignore writes, read zero
module channel_global_clock_config
  import chan_cfg_pkg::*;
#(
  parameter int unsigned SETTLE_CYCLES = XTAL_SETTLE_CYCLES  // Crystal settle count.
)
(
  input  wire logic              sys_clk,           // System clock, 50 MHz.
  input  wire logic              sys_rst,           // Synchronous reset, active high.
  input  wire logic              channelResetPinN,  // Channel reset pin, active low, asynchronous.
  input  wire logic [1:0]        crystalModeStrap,  // Pin-programmed crystal mode default.
  input  wire logic              regWrEn,           // Register write strobe.
  input  wire logic              regRdEn,           // Register read strobe.
  input  wire logic [ADDR_W-1:0] regAddr,           // Register address.
  input  wire logic [7:0]        regWrData,         // Register write data.
  output logic [7:0]             regRdData,         // Register read data.
  output logic                   regRdValid,        // Read data valid, one cycle.
  input  wire logic              extSwitchEnable,   // External switch enable from the loop block.
  output logic                   channelInReset,    // Channel held in reset.
  output mclk_src_t              masterSource,      // Selected master clock source.
  output logic                   ringOscEnable,     // Ring oscillator running.
  output logic                   doublerOn,         // Clock doubler powered.
  output logic                   xtalDriverOn,      // Crystal driver enabled.
  output logic                   xtalInputOn,       // Oscillator input enabled.
  output logic                   singleEndedOn,     // Single-ended oscillator input mode.
  output logic [3:0]             extSwitchSel,      // One-hot external switch GPIO select.
  output logic                   synthBlockOn,      // Oscillator/spread block powered.
  output logic                   loopOn,            // Analog loop powered.
  output logic [2:0]             inputOn,           // Input clock enables.
  output logic                   synthClockReady,   // Synth block ready to run on crystal.
  output logic                   crystalSettled     // Crystal driver or single-ended input mode on for the settle time.
);

  // ****************************************************************
  // State
  // ****************************************************************

  typedef struct packed {
    cfg_fields_t         cfg;
    logic                resetBit;
    logic                bankSel;
    logic                pinMeta;
    logic                pinSync;
    logic [1:0]          strapMeta;
    logic [1:0]          strapSync;
    logic [1:0]          strapLatched;
    logic [7:0]          rdData;
    logic                rdValid;
    logic                rdFromMem;
    logic [SETTLE_W-1:0] settleCnt;
    logic                settled;
  } top_state_t;

  top_state_t st_ff;
  top_state_t nxt_st;

  localparam logic [SETTLE_W-1:0] SETTLE_LAST = SETTLE_W'(SETTLE_CYCLES - 1);

  mem_port_if memPort ();

  logic        pinReset;
  logic        memSel;
  logic        regWrite;
  cfg_fields_t defaults;
  logic [7:0]  readValue;

  // ****************************************************************
  // Field defaults and decode of the access
  // ****************************************************************

  // Pin reset is taken from the synchronised pin; the strap default comes from the latch.
  assign pinReset = !st_ff.pinSync;
  assign memSel   = isMemAccess(st_ff.bankSel, regAddr); // [RQ1]
  assign regWrite = regWrEn && !memSel;

  // Every field defaults to zero except the pin-programmed crystal mode.
  always_comb begin
    defaults             = '0;
    defaults.crystalMode = xtal_mode_t'(st_ff.strapLatched); // [RQ4]
  end

  // Readback value of the addressed register; unimplemented bits read zero.
  always_comb begin
    readValue = REG_RESET;
    case (regAddr)
      ADDR_BANK_SELECT: begin
        readValue = REG_RESET; // [RQ2]
      end
      ADDR_MASTER_ONE: begin
        readValue[M1_RESET_BIT]              = st_ff.resetBit;
        readValue[M1_IC1_OVR_BIT]            = st_ff.cfg.ic1Override;
        readValue[M1_SRC_SEL_BIT]            = st_ff.cfg.srcSelect;
        readValue[M1_RING_PD_BIT]            = st_ff.cfg.ringPowerDown;
        readValue[M1_DBL_BIT]                = st_ff.cfg.doublerEnable;
        readValue[M1_XTAL_LSB+1:M1_XTAL_LSB] = st_ff.cfg.crystalMode;
      end
      ADDR_MASTER_TWO: begin
        readValue[M2_GPIO_LSB+1:M2_GPIO_LSB] = st_ff.cfg.gpioSelect;
      end
      ADDR_BLOCK_POWER: begin
        readValue[PE_SYNTH_BIT] = st_ff.cfg.synthEnable;
        readValue[PE_LOOP_BIT]  = st_ff.cfg.loopEnable;
      end
      ADDR_INPUT_ENABLE: begin
        readValue[IC_ENABLE_LSB+2:IC_ENABLE_LSB] = st_ff.cfg.inputEnable;
      end
      default: begin
        readValue = REG_RESET; // [RQ16]
      end
    endcase
  end

  // ****************************************************************
  // Next state
  // ****************************************************************

  always_comb begin
    nxt_st = st_ff;

    // Two-flop synchronisers for the reset pin and the strap pins.
    nxt_st.pinMeta   = channelResetPinN;
    nxt_st.pinSync   = st_ff.pinMeta;
    nxt_st.strapMeta = crystalModeStrap;
    nxt_st.strapSync = st_ff.strapMeta;

    // The strap is captured only while the reset pin is active.
    if (pinReset) begin
      nxt_st.strapLatched = st_ff.strapSync; // [RQ4]
    end

    // The bank select sits at offset zero in both banks.
    if (regWrEn && (regAddr == ADDR_BANK_SELECT)) begin
      nxt_st.bankSel = regWrData[BANK_BIT]; // [RQ1]
    end

    // Register writes; only the documented bits are stored.
    if (regWrite) begin
      case (regAddr)
        ADDR_MASTER_ONE: begin
          nxt_st.resetBit          = regWrData[M1_RESET_BIT];
          nxt_st.cfg.ic1Override   = regWrData[M1_IC1_OVR_BIT];          // [RQ6]
          nxt_st.cfg.srcSelect     = regWrData[M1_SRC_SEL_BIT];          // [RQ7]
          nxt_st.cfg.ringPowerDown = regWrData[M1_RING_PD_BIT];          // [RQ9]
          nxt_st.cfg.doublerEnable = regWrData[M1_DBL_BIT];
          nxt_st.cfg.crystalMode   = xtal_mode_t'(regWrData[M1_XTAL_LSB+1:M1_XTAL_LSB]); // [RQ11]
        end
        ADDR_MASTER_TWO: begin
          nxt_st.cfg.gpioSelect = regWrData[M2_GPIO_LSB+1:M2_GPIO_LSB]; // [RQ12]
        end
        ADDR_BLOCK_POWER: begin
          nxt_st.cfg.synthEnable = regWrData[PE_SYNTH_BIT];             // [RQ13]
          nxt_st.cfg.loopEnable  = regWrData[PE_LOOP_BIT];
        end
        ADDR_INPUT_ENABLE: begin
          nxt_st.cfg.inputEnable = regWrData[IC_ENABLE_LSB+2:IC_ENABLE_LSB]; // [RQ15]
        end
        default: begin
          nxt_st.cfg = nxt_st.cfg; // [RQ16]
        end
      endcase
    end

    // While the reset bit is set, every other field is forced to its default.
    if (nxt_st.resetBit) begin
      nxt_st.cfg     = defaults; // [RQ3] [RQ4]
      nxt_st.bankSel = 1'b0;     // [RQ3]
    end

    // The reset pin clears every field and the bank select, the reset bit included, and uses the live strap.
    if (pinReset) begin
      nxt_st.cfg             = '0;
      nxt_st.cfg.crystalMode = xtal_mode_t'(st_ff.strapSync); // [RQ4]
      nxt_st.resetBit        = 1'b0;
      nxt_st.bankSel         = 1'b0;
    end

    // Read answer: register value here, memory value from the memory's register.
    nxt_st.rdValid   = regRdEn;
    nxt_st.rdFromMem = regRdEn && memSel;
    if (regRdEn && !memSel) begin
      nxt_st.rdData = readValue;
    end

    // Settle timer runs while the crystal input is on and restarts when it goes off.
    if (st_ff.cfg.crystalMode == XTAL_OFF || st_ff.cfg.crystalMode == XTAL_UNUSED) begin
      nxt_st.settleCnt = '0;
      nxt_st.settled   = 1'b0;
    end else if (st_ff.settleCnt == SETTLE_LAST) begin
      nxt_st.settled = 1'b1;
    end else begin
      nxt_st.settleCnt = st_ff.settleCnt + SETTLE_W'(1);
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************

  // The system reset loads constants only; the pin synchronisers idle released.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_ff              <= '0;
      st_ff.pinMeta      <= 1'b1;
      st_ff.pinSync      <= 1'b1;
      st_ff.strapLatched <= STRAP_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ****************************************************************
  // Configuration memory
  // ****************************************************************

  // Memory accesses go through only when the bank select points at memory.
  assign memPort.wrEn   = regWrEn && memSel;
  assign memPort.rdEn   = regRdEn && memSel;
  assign memPort.addr   = regAddr[MEM_AW-1:0];
  assign memPort.wrData = regWrData;

  cfg_memory u_mem (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .port    (memPort.memory)
  );

  // ****************************************************************
  // Clock source and power decode
  // ****************************************************************

  clk_source_decode u_dec (
    .sys_clk         (sys_clk),
    .sys_rst         (sys_rst),
    .cfg             (st_ff.cfg),
    .extSwitchEnable (extSwitchEnable),
    .masterSource    (masterSource),
    .ringOscEnable   (ringOscEnable),
    .doublerOn       (doublerOn),
    .xtalDriverOn    (xtalDriverOn),
    .xtalInputOn     (xtalInputOn),
    .singleEndedOn   (singleEndedOn),
    .extSwitchSel    (extSwitchSel),
    .synthBlockOn    (synthBlockOn),
    .loopOn          (loopOn),
    .inputOn         (inputOn),
    .synthClockReady (synthClockReady)
  );

  // ****************************************************************
  // Outputs
  // ****************************************************************

  // Both read sources are registers; the select picks the one that answered.
  assign regRdData      = st_ff.rdFromMem ? memPort.rdData : st_ff.rdData;
  assign regRdValid     = st_ff.rdValid;
  assign channelInReset = st_ff.resetBit || pinReset; // [RQ3]
  assign crystalSettled = st_ff.settled;

endmodule

// ===== testbench/chan_cfg_checker.sv
// Assertion checker for the channel global configuration block.
`timescale 1ns/100ps
module chan_cfg_checker
  import chan_cfg_pkg::*;
#(
  parameter int unsigned SETTLE_CYCLES = 20  // Crystal settle count.
)
(
  input wire logic        sys_clk,           // Clock.
  input wire logic        sys_rst,           // Reset.
  input wire logic        channelResetPinN,  // Reset pin.
  input wire logic        regRdEn,           // Read strobe.
  input wire logic [10:0] regAddr,           // Address.
  input wire logic [7:0]  regRdData,         // Read data.
  input wire logic        regRdValid,        // Read valid.
  input wire logic        extSwitchEnable,   // Switch enable.
  input wire logic        channelInReset,    // In reset.
  input wire mclk_src_t   masterSource,      // Source.
  input wire logic        ringOscEnable,     // Ring on.
  input wire logic        xtalDriverOn,      // Driver on.
  input wire logic        xtalInputOn,       // Input on.
  input wire logic        singleEndedOn,     // Single ended.
  input wire logic [3:0]  extSwitchSel,      // Switch select.
  input wire logic        synthBlockOn,      // Synth on.
  input wire logic [2:0]  inputOn,           // Input enables.
  input wire logic        synthClockReady,   // Synth ready.
  input wire logic        crystalSettled     // Settled.
);
  logic [31:0] onCnt;

  // ****************************************************************
  // Helper logic
  // ****************************************************************
  // Counts unbroken cycles with the oscillator input powered.
  always_ff @(posedge sys_clk) begin
    if (sys_rst || !xtalInputOn) begin
      onCnt <= '0;
    end else begin
      onCnt <= onCnt + 32'h1;
    end
  end

  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  sequence s_pin_low; !channelResetPinN [*3]; endsequence
  sequence s_held_rst; channelInReset [*3]; endsequence
  property p_bank_read; regRdEn && regAddr == ADDR_BANK_SELECT |=> regRdValid && regRdData == 8'h00; endproperty
  property p_pin_reset; s_pin_low |-> channelInReset; endproperty
  property p_defaults;
    s_held_rst |-> masterSource == SRC_RING && ringOscEnable && !synthBlockOn && inputOn == 3'h0;
  endproperty
  property p_release; $past(sys_rst) |-> masterSource == SRC_RING && ringOscEnable; endproperty
  property p_xtal; !(xtalDriverOn && singleEndedOn) && xtalInputOn == (xtalDriverOn || singleEndedOn); endproperty
  property p_ready; synthClockReady == (synthBlockOn && masterSource == SRC_XTAL && xtalInputOn); endproperty
  property p_switch; $onehot0(extSwitchSel) && ((extSwitchSel != 4'h0) == $past(extSwitchEnable)); endproperty
  property p_settle_min; crystalSettled |-> onCnt + 32'h3 >= SETTLE_CYCLES; endproperty
  property p_settle_clr; !xtalInputOn [*2] |-> !crystalSettled; endproperty

  a_bank_read: assert property (p_bank_read) else $error("bank select read not zero");
  a_pin_reset: assert property (p_pin_reset) else $error("pin reset not seen");
  a_defaults: assert property (p_defaults) else $error("fields not default in reset");
  a_release: assert property (p_release) else $error("ring not selected after reset");
  a_xtal: assert property (p_xtal) else $error("crystal mode decode wrong");
  a_ready: assert property (p_ready) else $error("synth ready wrong");
  a_switch: assert property (p_switch) else $error("switch select wrong");
  a_settle_min: assert property (p_settle_min) else $error("settled too early");
  a_settle_clr: assert property (p_settle_clr) else $error("settled not cleared");
endmodule

// ===== testbench/channel_global_clock_config_tb.sv
// Self-checking testbench for the channel global configuration block.
`timescale 1ns/100ps
module channel_global_clock_config_tb;
  import chan_cfg_pkg::*;
  localparam int SETTLE = 20;
  logic        sys_clk, sys_rst, channelResetPinN, regWrEn, regRdEn, regRdValid, extSwitchEnable;
  logic        channelInReset, ringOscEnable, doublerOn, xtalDriverOn, xtalInputOn, singleEndedOn;
  logic        synthBlockOn, loopOn, synthClockReady, crystalSettled;
  logic [1:0]  crystalModeStrap;
  logic [10:0] regAddr;
  logic [7:0]  regWrData, regRdData, m1, m2, pe, ic;
  logic [3:0]  extSwitchSel;
  logic [2:0]  inputOn;
  logic [16:0] outs;
  mclk_src_t   masterSource;
  int          nFail = 0;
  int          nCompared = 0;

  // Gathers the decode outputs for one comparison.
  assign outs = {masterSource, ringOscEnable, doublerOn, xtalDriverOn, xtalInputOn, singleEndedOn, extSwitchSel,
                 synthBlockOn, loopOn, inputOn, synthClockReady};

  channel_global_clock_config #(.SETTLE_CYCLES(SETTLE)) uut (
    .sys_clk, .sys_rst, .channelResetPinN, .crystalModeStrap, .regWrEn, .regRdEn, .regAddr, .regWrData,
    .regRdData, .regRdValid, .extSwitchEnable, .channelInReset, .masterSource, .ringOscEnable, .doublerOn,
    .xtalDriverOn, .xtalInputOn, .singleEndedOn, .extSwitchSel, .synthBlockOn, .loopOn, .inputOn,
    .synthClockReady, .crystalSettled
  );

  // Toggles the 50 MHz clock.
  always #10 sys_clk = ~sys_clk;

  // Works out the decode outputs from register contents.
  function automatic logic [16:0] expOut(input logic [7:0] a, b, c, d, input logic ext);
    logic [1:0] s;
    logic       xi;
    s = a[5] ? 2'b10 : {1'b0, a[4]};
    xi = a[1:0] == 2'b01 || a[1:0] == 2'b10;
    expOut = {s, !a[3], a[2], a[1:0] == 2'b01, xi, a[1:0] == 2'b10, ext ? 4'h1 << b[6:5] : 4'h0,
              c[4], c[0], d[2:0], c[4] && s == 2'b01 && xi};
  endfunction

  task automatic chk(input logic [16:0] got, exp, input string msg);
    nCompared++;
    if (got !== exp) begin
      nFail++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic wr(input logic [10:0] a, input logic [7:0] d);
    @(posedge sys_clk); #1;
    regWrEn = 1'b1; regAddr = a; regWrData = d;
    @(posedge sys_clk); #1;
    regWrEn = 1'b0;
  endtask

  task automatic rd(input logic [10:0] a, input logic [7:0] e);
    @(posedge sys_clk); #1;
    regRdEn = 1'b1; regAddr = a;
    @(posedge sys_clk); #1;
    regRdEn = 1'b0;
    chk({regRdValid, regRdData}, {1'b1, e}, "read");
  endtask

  task automatic endSim;
    $display("Compared %0d, failed %0d", nCompared, nFail);
    if (nFail == 0 && nCompared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Main sequence of scenarios.
  initial begin
    sys_clk = 0; sys_rst = 1; channelResetPinN = 1; crystalModeStrap = 2'h0; regWrEn = 0; regRdEn = 0;
    regAddr = 11'h000; regWrData = 8'h00; extSwitchEnable = 0;
    void'($urandom(32'h3d54));
    repeat (10) @(posedge sys_clk);
    #1 sys_rst = 0;
    chk(outs, expOut(8'h00, 8'h00, 8'h00, 8'h00, 1'b0), "reset outputs");
    foreach (m1[i]) if (i < 5) rd(i == 0 ? 11'h000 : 11'h008 + 11'(i), 8'h00);
    rd(11'h7ff, 8'h00);
    for (int i = 0; i < 32; i++) begin
      m1 = 8'($urandom()) & 8'h7f;
      m1[1:0] = i[1:0];
      m2 = 8'($urandom());
      m2[6:5] = i[3:2];
      pe = 8'($urandom());
      ic = 8'($urandom());
      extSwitchEnable = 1'($urandom());
      wr(11'h009, m1); wr(11'h00a, m2); wr(11'h00b, pe); wr(11'h00c, ic);
      rd(11'h009, m1 & 8'h3f); rd(11'h00a, m2 & 8'h60); rd(11'h00b, pe & 8'h11); rd(11'h00c, ic & 8'h07);
      chk(outs, expOut(m1, m2, pe, ic, extSwitchEnable), "decode");
    end
    wr(11'h000, 8'h01); wr(11'h005, 8'h5a); wr(11'h009, 8'ha5);
    rd(11'h005, 8'h5a); rd(11'h009, 8'ha5);
    wr(11'h000, 8'h00);
    rd(11'h009, m1 & 8'h3f);
    crystalModeStrap = 2'b10; channelResetPinN = 0;
    repeat (4) @(posedge sys_clk);
    #1 chk(channelInReset, 1, "pin reset");
    channelResetPinN = 1;
    repeat (3) @(posedge sys_clk);
    #1 crystalModeStrap = 2'b01;
    rd(11'h009, 8'h02); rd(11'h00b, 8'h00);
    wr(11'h009, 8'h3d); wr(11'h009, 8'h05); wr(11'h009, 8'h85);
    chk(channelInReset, 1, "soft reset");
    wr(11'h00b, 8'h11);
    rd(11'h00b, 8'h00); rd(11'h009, 8'h82);
    chk(outs, expOut(8'h02, 8'h00, 8'h00, 8'h00, extSwitchEnable), "reset decode");
    wr(11'h009, 8'h00); wr(11'h009, 8'h01);
    chk(channelInReset, 0, "reset cleared");
    repeat (SETTLE / 2) @(posedge sys_clk);
    #1 chk(crystalSettled, 0, "early settle");
    repeat (SETTLE) @(posedge sys_clk);
    #1 chk(crystalSettled, 1, "settled");
    wr(11'h009, 8'h11); wr(11'h00b, 8'h11);
    @(posedge sys_clk);
    #1 chk(outs, expOut(8'h11, 8'h00, 8'h11, 8'h00, extSwitchEnable), "crystal run");
    wr(11'h009, 8'h00);
    repeat (2) @(posedge sys_clk);
    #1 chk(crystalSettled, 0, "settle cleared");
    endSim;
  end

  // Cuts a hang short.
  initial begin
    #200000;
    nFail++;
    endSim;
  end
endmodule

bind channel_global_clock_config chan_cfg_checker #(.SETTLE_CYCLES(SETTLE_CYCLES)) chk (
  .sys_clk, .sys_rst, .channelResetPinN, .regRdEn, .regAddr, .regRdData, .regRdValid, .extSwitchEnable,
  .channelInReset, .masterSource, .ringOscEnable, .xtalDriverOn, .xtalInputOn, .singleEndedOn, .extSwitchSel,
  .synthBlockOn, .inputOn, .synthClockReady, .crystalSettled
);
